// File: tb/pwm_load_model.sv
// Load model on the modulated output pin that times every pulse it receives.
`timescale 1ns/1ps
module pwm_load_model (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_pin,
    input wire logic i_oe,
    output logic [15:0] o_high,
    output logic [15:0] o_period,
    output logic o_done
);
    logic prev;
    logic seen;
    logic [15:0] cnt;
    logic [15:0] hcnt;
    // An undriven pin floats, so the load forgets its timing and waits for a fresh edge.
    always_ff @(posedge i_clk) begin
        prev <= i_pin & i_oe;
        o_done <= 1'b0;
        if (!i_rst_n || !i_oe) begin
            seen <= 1'b0;
        end else if (i_pin && !prev) begin
            o_done <= seen;
            o_period <= cnt;
            o_high <= hcnt;
            seen <= 1'b1;
            cnt <= 16'h0001;
            hcnt <= 16'h0001;
        end else begin
            cnt <= cnt + 16'h0001;
            hcnt <= hcnt + {15'h0000, i_pin};
        end
    end
endmodule : pwm_load_model

// File: tb/testbench.sv
// Self-checking bench for the pulse-width generator and its register bus.
`timescale 1ns/1ps
module testbench;
    import pwm_timebase_pkg::*;
    logic clk, rst_n, awvalid, wvalid, bready, arvalid, rready;
    logic awready, wready, bvalid, arready, rvalid, pin, oe, done;
    logic [31:0] awaddr, wdata, araddr, rdata;
    logic [1:0] bresp, rresp;
    logic [15:0] m_high, m_per;
    logic [65:0] rq[$];
    logic [1:0] bq[$];
    logic [31:0] pq[$];
    int error_cnt = 0;
    int n_tests = 0;
    int seed = 69140;
    ////////////////////////////////////////////////////////////////////////////
    pwm_timebase i_dut (.I_SYS_CLK(clk), .I_RST_N(rst_n), .I_AWADDR(awaddr),
        .I_AWVALID(awvalid), .O_AWREADY(awready), .I_WDATA(wdata), .I_WSTRB(4'hF),
        .I_WVALID(wvalid), .O_WREADY(wready), .O_BRESP(bresp), .O_BVALID(bvalid),
        .I_BREADY(bready), .I_ARADDR(araddr), .I_ARVALID(arvalid), .O_ARREADY(arready),
        .O_RDATA(rdata), .O_RRESP(rresp), .O_RVALID(rvalid), .I_RREADY(rready),
        .O_PWM_OUT_PIN(pin), .O_PWM_OUT_PIN_OE(oe));
    pwm_load_model i_load (.i_clk(clk), .i_rst_n(rst_n), .i_pin(pin), .i_oe(oe),
        .o_high(m_high), .o_period(m_per), .o_done(done));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic close_out();
        if (error_cnt == 0 && n_tests > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : close_out
    task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] r = RESP_OKAY);
        bq.push_back(r);
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (!(bvalid && bready));
        bready <= 1'b0;
    endtask : wr
    task automatic rd(input logic [31:0] a, input logic [31:0] exp, output logic [31:0] got,
                      input logic [31:0] mask = '1, input logic [1:0] r = RESP_OKAY);
        rq.push_back({mask, exp, r});
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clk);
            if (arvalid && arready) arvalid <= 1'b0;
        end while (!(rvalid && rready));
        got = rdata;
        rready <= 1'b0;
    endtask : rd
    // Follows the documented bring-up order so the first pulse on the pin is whole.
    task automatic setup(input logic [7:0] per, input logic [9:0] duty, input logic [1:0] ps);
        logic [31:0] got;
        wr(32'(OFF_ENABLES), 32'(1) << PIN_DIR_BIT);
        wr(32'(OFF_PERIOD), {24'h0, per});
        wr(32'(OFF_CCP_CONTROL), {24'h0, 2'b00, duty[1:0], PWM_MODE_CODE});
        wr(32'(OFF_DUTY_HIGH), {24'h0, duty[9:2]});
        wr(32'(OFF_FLAGS), 32'h0);
        wr(32'(OFF_TIMER_CONTROL), {24'h0, 5'h00, 1'b1, ps});
        do rd(32'(OFF_FLAGS), 32'h0, got, 32'h0); while (got[PERIOD_MATCH_BIT] !== 1'b1);
        rd(32'(OFF_FLAGS), 32'h2, got, 32'h2);
        wr(32'(OFF_ENABLES), 32'h0);
        repeat (2) @(posedge clk);
        #1 check({31'h0, oe}, 32'h1);
    endtask : setup
    ////////////////////////////////////////////////////////////////////////////
    always @(posedge clk) begin
        logic [65:0] e;
        if (bvalid && bready) check({30'h0, bresp}, {30'h0, bq.pop_front()});
        if (rvalid && rready) begin
            e = rq.pop_front();
            check(rdata & e[65:34], e[33:2]);
            check({30'h0, rresp}, {30'h0, e[1:0]});
        end
        if (done && pq.size() > 0) check({m_high, m_per}, pq.pop_front());
    end
    // Longest path is four prescale settings of a few long periods each; this is ample.
    initial begin
        #800000;
        error_cnt++;
        close_out();
    end
    initial begin
        logic [31:0] got;
        logic [7:0] per;
        logic [9:0] duty;
        int ratio;
        logic [7:0] rst_val [8];
        rst_val = '{CCP_CONTROL_RST, BYTE_ZERO, BYTE_ZERO, PERIOD_RST, BYTE_ZERO,
                    TIMER_CONTROL_RST, FLAGS_RST, ENABLES_RST};
        {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
        awaddr = 32'h0;
        wdata = 32'h0;
        araddr = 32'h0;
        rst_n = 1'b0;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 8; i++) rd(32'(i * 4), {24'h0, rst_val[i]}, got);
        check({31'h0, oe}, 32'h0);
        rd(32'h20, 32'h0, got, '1, RESP_SLVERR);
        wr(32'h03, 32'h0, RESP_SLVERR);
        wr(32'h20, 32'hFF);
        for (int i = 0; i < 2; i++) begin
            wr(32'(OFF_TIMER_CONTROL), i ? (32'(1) << TIMEBASE_ON_BIT) | (32'(1) << SLEEP_BIT) : 32'h0);
            wr(32'(OFF_COUNTER), 32'h25 + 32'(i));
            repeat (40) @(posedge clk);
            rd(32'(OFF_COUNTER), 32'h25 + 32'(i), got);
        end
        wr(32'(OFF_TIMER_CONTROL), 32'h0);
        for (int ps = 0; ps < 4; ps++) begin
            per = 8'($unsigned($random(seed)) % 8 + 2);
            duty = 10'($unsigned($random(seed)) % (4 * (per + 1) - 1) + 1);
            ratio = (ps == 0) ? 1 : (ps == 1) ? 4 : 16;
            setup(per, duty, 2'(ps));
            repeat (3) @(posedge clk iff done);
            repeat (2) pq.push_back({16'(duty * ratio), 16'((per + 1) * 4 * ratio)});
            wait (pq.size() == 0);
            wr(32'(OFF_DUTY_BUFFER), 32'h5A);
            rd(32'(OFF_DUTY_BUFFER), {24'h0, duty[9:2]}, got);
        end
        for (int k = 0; k < 2; k++) begin
            setup(8'h03, k ? 10'h014 : 10'h000, PRESCALE_1);
            repeat (20) @(posedge clk);
            for (int j = 0; j < 4; j++) begin
                repeat (5) @(posedge clk);
                #1 check({31'h0, pin}, 32'(k));
            end
        end
        wr(32'(OFF_CCP_CONTROL), 32'h0);
        repeat (2) @(posedge clk);
        #1 check({31'h0, oe}, 32'h0);
        close_out();
    end
endmodule : testbench

// File: verilog/pwm_timebase.sv
// Standard pulse-width generator on an 8-bit period timer with AXI4-Lite registers.
//
// Design decisions made here: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
module pwm_timebase
    import pwm_timebase_pkg::*;
(
    input wire logic I_SYS_CLK,
    input wire logic I_RST_N,
    input wire logic [31:0] I_AWADDR,
    input wire logic I_AWVALID,
    output logic O_AWREADY,
    input wire logic [31:0] I_WDATA,
    input wire logic [3:0] I_WSTRB,
    input wire logic I_WVALID,
    output logic O_WREADY,
    output logic [1:0] O_BRESP,
    output logic O_BVALID,
    input wire logic I_BREADY,
    input wire logic [31:0] I_ARADDR,
    input wire logic I_ARVALID,
    output logic O_ARREADY,
    output logic [31:0] O_RDATA,
    output logic [1:0] O_RRESP,
    output logic O_RVALID,
    input wire logic I_RREADY,
    output logic O_PWM_OUT_PIN,
    output logic O_PWM_OUT_PIN_OE
);
    logic [7:0] ccp_control;
    logic [7:0] duty_high_bits;
    logic [7:0] duty_buffer;
    logic [1:0] duty_low_latch;
    logic [7:0] period_reg;
    logic [7:0] timebase_counter;
    logic [7:0] timer_control;
    logic [7:0] peripheral_flags;
    logic [7:0] peripheral_enables;
    logic [3:0] prescaler;
    logic [1:0] osc_phase;
    logic pwm_level;
    logic pwm_started;
    logic set_pending;
    logic aw_upper;

    logic aw_held;
    logic w_held;
    logic [4:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;

    logic pwm_mode;
    logic sleeping;
    logic running;
    logic inc_tick;
    logic period_hit;
    logic [1:0] time_low;
    logic [9:0] time_base;
    logic [9:0] duty_live;
    logic [9:0] duty_buf10;
    logic do_write;
    logic wr_byte0;
    logic [7:0] wbyte;

    ////////////////////////////////////////////////////////////////////////////
    // Control decode.
    assign pwm_mode = (ccp_control[MODE_LSB +: 4] == PWM_MODE_CODE);
    assign sleeping = timer_control[SLEEP_BIT];
    assign running = timer_control[TIMEBASE_ON_BIT] && !sleeping;
    assign duty_live = {duty_high_bits, ccp_control[DUTY_LOW_LSB +: 2]};
    assign duty_buf10 = {duty_buffer, duty_low_latch};

    // One timer increment is four oscillator clocks times the prescale ratio.
    always_comb begin
        case (timer_control[PRESCALE_LSB +: 2])
            PRESCALE_1: inc_tick = running && (osc_phase == QUARTER_LAST);
            PRESCALE_4: inc_tick = running && (osc_phase == QUARTER_LAST)
                                   && (prescaler[1:0] == QUARTER_LAST);
            default: inc_tick = running && (osc_phase == QUARTER_LAST)
                                && (prescaler == 4'hF);
        endcase
    end

    // Low time-base bits: oscillator phase at 1:1, the low prescaler bits at 1:4, else the top prescaler bits.
    always_comb begin
        case (timer_control[PRESCALE_LSB +: 2])
            PRESCALE_1: time_low = osc_phase;
            PRESCALE_4: time_low = prescaler[1:0];
            default: time_low = prescaler[3:2];
        endcase
    end
    assign time_base = {timebase_counter, time_low};
    // The postscaler is not part of this path at all.
    assign period_hit = inc_tick && (timebase_counter == period_reg);

    ////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite write channel: address and data are taken in either order.
    assign do_write = aw_held && w_held && !O_BVALID;
    // Addresses above the register window are ignored rather than aliased.
    assign wr_byte0 = do_write && w_strb[0] && !aw_upper;
    assign wbyte = w_data[7:0];

    always_ff @(posedge I_SYS_CLK) begin
        if (!I_RST_N) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 5'h00;
            aw_upper <= 1'b0;
            w_data <= 32'h00000000;
            w_strb <= 4'h0;
            O_AWREADY <= 1'b0;
            O_WREADY <= 1'b0;
            O_BVALID <= 1'b0;
            O_BRESP <= RESP_OKAY;
        end else begin
            O_AWREADY <= !aw_held && !O_AWREADY && !O_BVALID;
            O_WREADY <= !w_held && !O_WREADY && !O_BVALID;
            if (I_AWVALID && O_AWREADY) begin
                aw_held <= 1'b1;
                aw_addr <= I_AWADDR[4:0];
                aw_upper <= |I_AWADDR[31:5];
                O_AWREADY <= 1'b0;
            end
            if (I_WVALID && O_WREADY) begin
                w_held <= 1'b1;
                w_data <= I_WDATA;
                w_strb <= I_WSTRB;
                O_WREADY <= 1'b0;
            end
            if (do_write) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                O_BVALID <= 1'b1;
                O_BRESP <= (aw_addr[1:0] == 2'h0) ? RESP_OKAY : RESP_SLVERR;
            end else if (O_BVALID && I_BREADY) begin
                O_BVALID <= 1'b0;
            end
        end
    end

    // Read channel: one read at a time, unmapped addresses read zero.
    always_ff @(posedge I_SYS_CLK) begin
        if (!I_RST_N) begin
            O_ARREADY <= 1'b0;
            O_RVALID <= 1'b0;
            O_RDATA <= 32'h00000000;
            O_RRESP <= RESP_OKAY;
        end else begin
            O_ARREADY <= !O_ARREADY && !O_RVALID;
            if (I_ARVALID && O_ARREADY) begin
                O_ARREADY <= 1'b0;
                O_RVALID <= 1'b1;
                O_RRESP <= RESP_OKAY;
                // Offset 1F is unmapped, so any high address bit lands in the default.
                case ((|I_ARADDR[31:5]) ? 5'h1F : I_ARADDR[4:0])
                    OFF_CCP_CONTROL: O_RDATA <= {24'h000000, ccp_control};
                    OFF_DUTY_HIGH: O_RDATA <= {24'h000000, duty_high_bits};
                    OFF_DUTY_BUFFER: O_RDATA <= {24'h000000, duty_buffer};
                    OFF_PERIOD: O_RDATA <= {24'h000000, period_reg};
                    OFF_COUNTER: O_RDATA <= {24'h000000, timebase_counter};
                    OFF_TIMER_CONTROL: O_RDATA <= {24'h000000, timer_control};
                    OFF_FLAGS: O_RDATA <= {24'h000000, peripheral_flags};
                    OFF_ENABLES: O_RDATA <= {24'h000000, peripheral_enables};
                    default: begin
                        O_RDATA <= 32'h00000000;
                        O_RRESP <= RESP_SLVERR;
                    end
                endcase
            end else if (O_RVALID && I_RREADY) begin
                O_RVALID <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Software-written registers.
    always_ff @(posedge I_SYS_CLK) begin
        if (!I_RST_N) begin
            ccp_control <= CCP_CONTROL_RST;
            duty_high_bits <= BYTE_ZERO;
            period_reg <= PERIOD_RST;
            timer_control <= TIMER_CONTROL_RST;
            peripheral_enables <= ENABLES_RST;
        end else if (wr_byte0) begin
            case (aw_addr)
                OFF_CCP_CONTROL: ccp_control <= wbyte;
                OFF_DUTY_HIGH: duty_high_bits <= wbyte;
                OFF_PERIOD: period_reg <= wbyte;
                OFF_TIMER_CONTROL: timer_control <= wbyte;
                OFF_ENABLES: peripheral_enables <= wbyte;
                default: ;
            endcase
        end
    end

    // Peripheral flags: hardware set wins over a software clear in the same cycle.
    always_ff @(posedge I_SYS_CLK) begin
        if (!I_RST_N) begin
            peripheral_flags <= FLAGS_RST;
        end else begin
            if (wr_byte0 && aw_addr == OFF_FLAGS) begin
                peripheral_flags <= wbyte;
            end
            if (period_hit) begin
                peripheral_flags[PERIOD_MATCH_BIT] <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Time base: oscillator phase, prescaler and 8-bit counter.
    always_ff @(posedge I_SYS_CLK) begin
        if (!I_RST_N) begin
            osc_phase <= 2'h0;
            prescaler <= 4'h0;
            timebase_counter <= BYTE_ZERO;
        end else if (wr_byte0 && aw_addr == OFF_COUNTER) begin
            timebase_counter <= wbyte;
            prescaler <= 4'h0;
        end else if (running) begin
            osc_phase <= osc_phase + 2'h1;
            if (osc_phase == QUARTER_LAST) begin
                prescaler <= prescaler + 4'h1;
            end
            if (period_hit) begin
                timebase_counter <= BYTE_ZERO;
                prescaler <= 4'h0;
            end else if (inc_tick) begin
                timebase_counter <= timebase_counter + 8'h01;
            end
        end
    end

    // Duty double buffer: latched at the end of a period in pulse-width mode, written by software otherwise.
    always_ff @(posedge I_SYS_CLK) begin
        if (!I_RST_N) begin
            duty_buffer <= BYTE_ZERO;
            duty_low_latch <= 2'h0;
        end else if (pwm_mode && period_hit) begin
            duty_buffer <= duty_live[9:2];
            duty_low_latch <= duty_live[1:0];
        end else if (!pwm_mode && wr_byte0 && aw_addr == OFF_DUTY_BUFFER) begin
            duty_buffer <= wbyte;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // The set is taken one cycle after the period match, because the clear also lands
    // one cycle after its compare; both edges shift alike and the high time stays exact.
    always_ff @(posedge I_SYS_CLK) begin
        if (!I_RST_N) begin
            set_pending <= 1'b0;
        end else begin
            set_pending <= pwm_mode && period_hit;
        end
    end

    // Output level: set at period start, cleared on the duty match.
    // Waiting for the first match avoids a truncated first waveform.
    always_ff @(posedge I_SYS_CLK) begin
        if (!I_RST_N) begin
            pwm_level <= 1'b0;
            pwm_started <= 1'b0;
        end else if (!pwm_mode) begin
            pwm_level <= 1'b0;
            pwm_started <= 1'b0;
        end else if (set_pending) begin
            pwm_started <= 1'b1;
            pwm_level <= (duty_buf10 != 10'h000);
        end else if (running && pwm_started && time_base == duty_buf10) begin
            pwm_level <= 1'b0;
        end
    end

    // Pin output registered; enabled only in pulse-width mode with direction cleared.
    always_ff @(posedge I_SYS_CLK) begin
        if (!I_RST_N) begin
            O_PWM_OUT_PIN <= 1'b0;
            O_PWM_OUT_PIN_OE <= 1'b0;
        end else begin
            O_PWM_OUT_PIN <= pwm_level;
            O_PWM_OUT_PIN_OE <= pwm_mode && !peripheral_enables[PIN_DIR_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    chk_counter_frozen: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N)
        sleeping && !wr_byte0 |=> timebase_counter == $past(timebase_counter))
        else $error("Counter moved while asleep.");
    chk_period_flag: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N)
        period_hit |=> peripheral_flags[PERIOD_MATCH_BIT])
        else $error("Period flag not set on rollover.");
    chk_rollover_clear: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N)
        period_hit && !wr_byte0 |=> timebase_counter == 8'h00)
        else $error("Counter not cleared on period match.");
    chk_duty_latch: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N)
        pwm_mode && period_hit |=> duty_buf10 == $past(duty_live))
        else $error("Duty not latched at period end.");
    chk_buffer_locked: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N)
        pwm_mode && !period_hit |=> duty_buffer == $past(duty_buffer))
        else $error("Duty buffer changed mid-period.");
    chk_zero_duty: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N)
        pwm_mode && period_hit && duty_live == 10'h000 |-> ##2 !pwm_level)
        else $error("Pin set with zero duty.");
    chk_level_set: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N)
        pwm_mode && period_hit && duty_live != 10'h000 ##1 pwm_mode |=> pwm_level)
        else $error("Pin not set at period start.");
    chk_match_clear: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N)
        pwm_mode && running && pwm_started && !set_pending && time_base == duty_buf10
        |=> !pwm_level)
        else $error("Pin not cleared on duty match.");

    ////////////////////////////////////////////////////////////////////////////
    // Sleep, pin, flag, counter step and duty buffer behaviour.
    chk_pin_follows: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N)
        pwm_mode |=> O_PWM_OUT_PIN == $past(pwm_level))
        else $error("Pin does not follow the internal level.");
    chk_level_asleep: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N)
        sleeping && pwm_mode && !set_pending |=> pwm_level == $past(pwm_level))
        else $error("Level changed while asleep.");
    chk_counter_step: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N)
        inc_tick && !period_hit && !wr_byte0
        |=> timebase_counter == $past(timebase_counter) + 8'h01)
        else $error("Counter did not step by one.");
    chk_flag_sticky: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N)
        peripheral_flags[PERIOD_MATCH_BIT] && !(wr_byte0 && aw_addr == OFF_FLAGS)
        |=> peripheral_flags[PERIOD_MATCH_BIT])
        else $error("Period flag cleared without software.");
    chk_dir_release: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N)
        peripheral_enables[PIN_DIR_BIT] |=> !O_PWM_OUT_PIN_OE)
        else $error("Pin driven while direction is input.");
    chk_buffer_free: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N)
        !pwm_mode && wr_byte0 && aw_addr == OFF_DUTY_BUFFER |=> duty_buffer == $past(wbyte))
        else $error("Duty buffer write lost outside pulse-width mode.");
    chk_reset_pin: assert property (@(posedge I_SYS_CLK)
        !I_RST_N |=> !O_PWM_OUT_PIN_OE && !O_PWM_OUT_PIN)
        else $error("Pin not released by reset.");

    ////////////////////////////////////////////////////////////////////////////
    // Bus answers stand until they are taken; pin release outside pulse-width mode; no tick while the timer is off.
    chk_bvalid_hold: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N)
        O_BVALID && !I_BREADY |=> O_BVALID && $stable(O_BRESP))
        else $error("Write response dropped before it was taken.");
    chk_rvalid_hold: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N)
        O_RVALID && !I_RREADY |=> O_RVALID && $stable(O_RDATA))
        else $error("Read data dropped before it was taken.");
    chk_pin_release: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N)
        !pwm_mode |=> !O_PWM_OUT_PIN_OE)
        else $error("Pin driven outside pulse-width mode.");
    chk_timer_off: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N)
        !timer_control[TIMEBASE_ON_BIT] |-> !inc_tick)
        else $error("Timer ticked while off.");
endmodule : pwm_timebase

// File: verilog/pwm_timebase_pkg.sv
// Constants for the standard single-output pulse-width generator.
package pwm_timebase_pkg;
    // Register byte offsets on the AXI4-Lite bus.
    localparam logic [4:0] OFF_CCP_CONTROL = 5'h00;
    localparam logic [4:0] OFF_DUTY_HIGH = 5'h04;
    localparam logic [4:0] OFF_DUTY_BUFFER = 5'h08;
    localparam logic [4:0] OFF_PERIOD = 5'h0C;
    localparam logic [4:0] OFF_COUNTER = 5'h10;
    localparam logic [4:0] OFF_TIMER_CONTROL = 5'h14;
    localparam logic [4:0] OFF_FLAGS = 5'h18;
    localparam logic [4:0] OFF_ENABLES = 5'h1C;
    // Field positions.
    localparam int DUTY_LOW_LSB = 4;
    localparam int MODE_LSB = 0;
    localparam int PRESCALE_LSB = 0;
    localparam int TIMEBASE_ON_BIT = 2;
    localparam int SLEEP_BIT = 3;
    localparam int PERIOD_MATCH_BIT = 1;
    localparam int PIN_DIR_BIT = 4;
    // Pulse-width mode select code in the low nibble of ccp_control.
    localparam logic [3:0] PWM_MODE_CODE = 4'hC;
    // Reset values.
    localparam logic [7:0] CCP_CONTROL_RST = 8'h00;
    localparam logic [7:0] PERIOD_RST = 8'hFF;
    localparam logic [7:0] TIMER_CONTROL_RST = 8'h00;
    localparam logic [7:0] FLAGS_RST = 8'h00;
    localparam logic [7:0] ENABLES_RST = 8'h00;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    // Last of the four oscillator phases in one timer increment.
    localparam logic [1:0] QUARTER_LAST = 2'h3;
    // Prescale codes.
    localparam logic [1:0] PRESCALE_1 = 2'h0;
    localparam logic [1:0] PRESCALE_4 = 2'h1;
    // AXI responses.
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : pwm_timebase_pkg
